// File: design/osc_ctrl.v
// oscillator start-up timer, mode control and register slave
`timescale 1ns/1ps
`include "osc_defs.vh"
module osc_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        por_event,
  input  wire        bor_event,
  input  wire        powerup_timer_done,
  input  wire        wake_event,
  input  wire        prog_mode,
  input  wire        osc_input_pin,
  input  wire        osc_lock_in,
  input  wire        osc_stable_in,
  input  wire        gpio_out,
  input  wire        gpio_oe,
  output wire        gpio_in,
  output wire        osc_output_pin_o,
  output wire        osc_output_pin_oe,
  input  wire        osc_output_pin_i,
  output wire        core_reset_hold,
  output wire        core_clk_en,
  output wire [1:0]  amp_gain,
  output wire        rc_osc_en,
  output wire [5:0]  trim_value,
  output wire        trim_update,
  output wire [1:0]  internal_freq_select,
  output wire        pll_enable_bit
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg  [2:0]  state_ff;
  reg  [2:0]  nxt_state;
  reg  [10:0] count_ff;
  reg  [10:0] nxt_count;
  reg  [1:0]  skip_ff;
  reg  [1:0]  nxt_skip;
  reg  [1:0]  freq_ff;
  reg  [5:0]  trim_ff;
  reg         trim_upd_ff;
  reg  [13:0] cfg_one_ff;
  reg  [13:0] cfg_two_ff;
  reg  [31:0] rdata_ff;
  reg         wr_ph_ff;
  reg  [11:0] wr_addr_ff;
  reg  [3:0]  div_ff;
  reg         divided_clock_output_ff;
  reg         gpio_in_ff;
  reg         startup_ff;
  wire        pin_lvl;
  wire        pin_rise;
  wire        lock_s;
  wire        stable_s;
  wire        io_s;
  wire [2:0]  mode;
  wire        crystal;
  wire        ext_clk;
  wire        rc_mode;
  wire        pin_is_io;
  wire        powerup_delay_timer_en;
  wire        start_evt;
  wire        addr_ok;
  wire [11:0] ofs;

  osc_edge_sync u_pin (.hclk(hclk), .hresetn(hresetn), .din(osc_input_pin),
    .level(pin_lvl), .rise(pin_rise));
  osc_edge_sync u_lock (.hclk(hclk), .hresetn(hresetn), .din(osc_lock_in),
    .level(lock_s), .rise());
  osc_edge_sync u_stab (.hclk(hclk), .hresetn(hresetn), .din(osc_stable_in),
    .level(stable_s), .rise());
  osc_edge_sync u_io (.hclk(hclk), .hresetn(hresetn), .din(osc_output_pin_i),
    .level(io_s), .rise());

  // mode from the first configuration word
  assign mode      = cfg_one_ff[2:0];
  assign powerup_delay_timer_en   = ~cfg_one_ff[4];
  assign pll_enable_bit = cfg_one_ff[12];
  assign crystal   = (mode == `OSC_MODE_LP) | (mode == `OSC_MODE_XT) | (mode == `OSC_MODE_HS);
  assign ext_clk   = (mode == `OSC_MODE_EC);
  assign rc_mode   = (mode == `OSC_MODE_RC) | (mode == `OSC_MODE_RC_NETWORK_IO_MODE);
  assign pin_is_io = ext_clk | (mode == `OSC_MODE_RC_NETWORK_IO_MODE);

  // wake or power-on (after the delay timer when enabled) starts the count
  assign start_evt = wake_event | (por_event & (~powerup_delay_timer_en | powerup_timer_done));

  always @*
  begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    nxt_skip  = skip_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (startup_ff | start_evt)
        begin
          nxt_count = 11'd0;
          nxt_skip  = 2'b11;
          nxt_state = crystal ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT:
      begin
        nxt_skip = {skip_ff[0], 1'b0};
        // rises still inside the synchroniser at the start predate the event
        if (pin_rise && !skip_ff[1])
          nxt_count = count_ff + 11'd1;
        if (start_evt)
        begin
          nxt_count = 11'd0;
          nxt_skip  = 2'b11;
          nxt_state = crystal ? ST_WAIT : ST_RUN;
        end
        else if (count_ff == `OSC_STARTUP_COUNT)
          nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        if (start_evt)
        begin
          nxt_count = 11'd0;
          nxt_skip  = 2'b11;
          nxt_state = crystal ? ST_WAIT : ST_RUN;
        end
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // first start follows the reset release once por qualifies
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff   <= ST_IDLE;
      count_ff   <= 11'd0;
      skip_ff    <= 2'b00;
      startup_ff <= 1'b0;
    end
    else
    begin
      state_ff   <= nxt_state;
      count_ff   <= nxt_count;
      skip_ff    <= nxt_skip;
      startup_ff <= 1'b0;
    end
  end

  assign core_reset_hold = ~state_ff[2];
  // external clock: core advances only on input edges, nothing is lost on stop
  assign core_clk_en = state_ff[2] & (ext_clk ? pin_rise : 1'b1);

  assign amp_gain = (mode == `OSC_MODE_LP) ? `OSC_GAIN_LOW :
                    (mode == `OSC_MODE_XT) ? `OSC_GAIN_MED :
                    (mode == `OSC_MODE_HS) ? `OSC_GAIN_HIGH : `OSC_GAIN_OFF;
  assign rc_osc_en = rc_mode;

  // divide-by-4: toggle every second rising edge of the rc input
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_ff    <= 4'h0;
      divided_clock_output_ff <= 1'b0;
    end
    else if ((mode == `OSC_MODE_RC) && pin_rise)
    begin
      div_ff <= {3'b000, ~div_ff[0]};
      if (div_ff[0])
        divided_clock_output_ff <= ~divided_clock_output_ff;
    end
  end

  assign osc_output_pin_o  = (mode == `OSC_MODE_RC) ? divided_clock_output_ff : gpio_out;
  assign osc_output_pin_oe = (mode == `OSC_MODE_RC) | (pin_is_io & gpio_oe);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gpio_in_ff <= 1'b0;
    else
      gpio_in_ff <= pin_is_io & io_s;
  end
  assign gpio_in = gpio_in_ff;

  // ahb-lite slave, zero wait states
  assign ofs     = wr_addr_ff;
  assign addr_ok = hsel & htrans[1] & hready;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph_ff   <= 1'b0;
      wr_addr_ff <= 12'h000;
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      wr_ph_ff <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_ff <= haddr[11:0];
      if (addr_ok & ~hwrite)
      begin
        case (haddr[11:0])
          `OSC_OFS_CTRL:
            rdata_ff <= {24'h0000_00, 2'b00, freq_ff, lock_s, stable_s, 2'b00};
          `OSC_OFS_TRIM:
            rdata_ff <= {24'h0000_00, 2'b00, trim_ff};
          `OSC_OFS_STATUS:
            rdata_ff <= {13'h0000, count_ff, 5'h00, state_ff};
          `OSC_OFS_CFG_ONE:
            rdata_ff <= prog_mode ? {18'h0_0000, cfg_one_ff} : 32'h0000_0000;
          `OSC_OFS_CFG_TWO:
            rdata_ff <= prog_mode ? {18'h0_0000, cfg_two_ff} : 32'h0000_0000;
          `OSC_OFS_GPIO:
            rdata_ff <= {31'h0000_0000, gpio_in_ff};
          default:
            rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // frequency select always resets to 10
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      freq_ff <= `OSC_FREQ_RESET;
    else if (wr_ph_ff && ofs == `OSC_OFS_CTRL)
      freq_ff <= hwdata[`OSC_FREQ_LSB+1:`OSC_FREQ_LSB];
  end

  // trim and config survive hresetn; only power-on or brown-out clears trim
  always @(posedge hclk)
  begin
    if (por_event | bor_event)
    begin
      trim_ff     <= `OSC_TRIM_RESET;
      trim_upd_ff <= 1'b0;
    end
    else if (wr_ph_ff && ofs == `OSC_OFS_TRIM)
    begin
      trim_ff     <= hwdata[5:0];
      trim_upd_ff <= 1'b1;
    end
    else
      trim_upd_ff <= 1'b0;
  end

  always @(posedge hclk)
  begin
    if (por_event & ~prog_mode)
    begin
      cfg_one_ff <= cfg_one_ff;
      cfg_two_ff <= cfg_two_ff;
    end
    else if (wr_ph_ff && prog_mode && ofs == `OSC_OFS_CFG_ONE)
      cfg_one_ff <= hwdata[13:0];
    else if (wr_ph_ff && prog_mode && ofs == `OSC_OFS_CFG_TWO)
      cfg_two_ff <= hwdata[13:0];
  end

  assign trim_value           = trim_ff;
  assign trim_update          = trim_upd_ff;
  assign internal_freq_select = freq_ff;
  assign hrdata    = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule // osc_ctrl

// File: design/osc_defs.vh
// constants for the oscillator start-up and mode control block
// Summary of operation
// - crystal modes count 1024 input-pin cycles before releasing the core
// - start-up count runs after power-on (post delay timer) and each sleep wake
// - core held, program counter frozen, while the count runs
// - external clock mode skips the start-up count entirely
// - external clock mode clocks from input pin, frees output pin for I/O
// - static logic: stopped external clock halts core, state kept
// - restarted external clock resumes exactly where it stopped
// - gain setting low, medium or high follows the crystal mode
// - rc clock-output mode drives output pin with rc frequency divided by 4
// - rc io mode uses input pin for rc, output pin becomes I/O
// - trim register bits 7-6 read zero, writes ignored
// - trim clears on power-on/brown-out only; freq select resets to 10 always
// - config words sit at 2007h and 2008h, programming mode only
// - trim value is six-bit two's complement frequency adjustment
// - frequency select reset value 10 selects 8 MHz or 250 kHz
// - trim write starts frequency shift, no completion flag
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH
`define OSC_OFS_CTRL      12'h000
`define OSC_OFS_TRIM      12'h004
`define OSC_OFS_STATUS    12'h008
`define OSC_OFS_CFG_ONE   12'h00C
`define OSC_OFS_CFG_TWO   12'h010
`define OSC_OFS_GPIO      12'h014
`define OSC_CFG_ONE_ADDR  14'h2007
`define OSC_CFG_TWO_ADDR  14'h2008
`define OSC_STARTUP_COUNT 11'd1024
`define OSC_FREQ_RESET    2'b10
`define OSC_FREQ_LSB      4
`define OSC_LOCK_BIT      3
`define OSC_STABLE_BIT    2
`define OSC_TRIM_RESET    6'h00
`define OSC_CFG_RESET     14'h3FFF
`define OSC_MODE_LP       3'b000
`define OSC_MODE_XT       3'b001
`define OSC_MODE_HS       3'b010
`define OSC_MODE_EC       3'b011
`define OSC_MODE_RC_NETWORK_IO_MODE     3'b100
`define OSC_MODE_RC       3'b101
`define OSC_GAIN_LOW      2'b01
`define OSC_GAIN_MED      2'b10
`define OSC_GAIN_HIGH     2'b11
`define OSC_GAIN_OFF      2'b00
`endif

// File: design/osc_edge_sync.v
// two-flop synchroniser with rising edge pulse
`timescale 1ns/1ps
module osc_edge_sync (
  input  wire hclk,
  input  wire hresetn,
  input  wire din,
  output wire level,
  output wire rise
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign level = s2_ff;
  assign rise  = s2_ff & ~s3_ff;
endmodule // osc_edge_sync

// File: tb/osc_ctrl_properties.sv
// assertions on the oscillator control block ports
`timescale 1ns/1ps
module osc_ctrl_properties (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic        por_event,
  input logic        bor_event,
  input logic        wake_event,
  input logic        osc_input_pin,
  input logic        core_reset_hold,
  input logic        core_clk_en,
  input logic [1:0]  amp_gain,
  input logic        rc_osc_en,
  input logic [5:0]  trim_value,
  input logic        trim_update,
  input logic [1:0]  internal_freq_select
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        pin_ff;
  logic        wr_ff;
  logic [5:0]  wd_ff;
  logic [11:0] cnt_ff;
  // saturates so a long run never wraps under the release bound
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_ff <= 12'h000;
    else if (wake_event || por_event)
      cnt_ff <= 12'h000;
    else if (osc_input_pin && !pin_ff && !cnt_ff[11])
      cnt_ff <= cnt_ff + 12'h001;
  end
  always @(posedge hclk)
  begin
    pin_ff <= osc_input_pin;
    wd_ff  <= hwdata[5:0];
    wr_ff  <= hsel && htrans[1] && hready && hwrite && (haddr[11:0] == 12'h004);
  end
  hold_blocks_clk_a: assert property (core_reset_hold |-> !core_clk_en)
    else $error("core clock enabled while held");
  startup_count_a: assert property ($fell(core_reset_hold) && amp_gain != 2'b00
    |-> cnt_ff >= 12'h400) else $error("released before full count");
  // this counter leads the synchroniser, so a small margin is allowed
  startup_end_a: assert property ($fell(core_reset_hold) && amp_gain != 2'b00
    |-> cnt_ff <= 12'h403) else $error("release late after count");
  wake_hold_a: assert property (wake_event && amp_gain != 2'b00
    |-> ##[1:4] core_reset_hold) else $error("wake did not hold core");
  trim_clear_a: assert property (por_event || bor_event |=> trim_value == 6'h00)
    else $error("trim not cleared");
  freq_reset_a: assert property ($rose(hresetn) |-> internal_freq_select == 2'b10)
    else $error("freq select not 10 after reset");
  trim_write_a: assert property (wr_ff && !por_event && !bor_event
    |=> trim_value == wd_ff) else $error("trim write lost");
  trim_pulse_a: assert property (wr_ff |-> ##[1:3] trim_update)
    else $error("no trim update pulse");
  gain_rc_excl_a: assert property (amp_gain != 2'b00 |-> !rc_osc_en)
    else $error("gain and rc both on");
  cover property ($fell(core_reset_hold) && amp_gain != 2'b00);
  cover property (trim_update);
  cover property (rc_osc_en && core_clk_en);
endmodule // osc_ctrl_properties

bind osc_ctrl osc_ctrl_properties u_osc_ctrl_properties (.*);

// File: tb/osc_ctrl_tb_top.sv
// testbench for the oscillator start-up and mode control block
`timescale 1ns/1ps
`include "osc_defs.vh"
module osc_ctrl_tb_top;
  logic        hclk, hresetn, hsel, hwrite, por_event, bor_event, wake_event;
  logic        prog_mode, osc_lock_in, osc_stable_in, gpio_out, gpio_oe, src_run;
  logic        powerup_delay_timer_done;
  wire         hresp, gpio_in;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire  [31:0] hrdata;
  wire  [5:0]  trim_value;
  wire  [1:0]  amp_gain, internal_freq_select;
  wire         hreadyout, osc_input_pin, osc_output_pin_o, osc_output_pin_oe;
  wire         core_reset_hold, core_clk_en, rc_osc_en;
  wire         pin_w = osc_output_pin_oe ? osc_output_pin_o : 1'b1;
  int          num_errors, n_compared, n_edge, n_tog, n_en, i;
  osc_ctrl u_osc_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .por_event, .bor_event,
    .powerup_timer_done(powerup_delay_timer_done), .wake_event, .prog_mode, .osc_input_pin,
    .osc_lock_in, .osc_stable_in, .gpio_out, .gpio_oe, .gpio_in,
    .osc_output_pin_o, .osc_output_pin_oe, .osc_output_pin_i(pin_w),
    .core_reset_hold, .core_clk_en, .amp_gain, .rc_osc_en, .trim_value,
    .trim_update(), .internal_freq_select, .pll_enable_bit()
  );
  osc_src_model u_osc_src_model (.run(src_run), .pin(osc_input_pin));
  always @(posedge osc_input_pin) n_edge++;
  always @(osc_output_pin_o) n_tog++;
  always @(posedge hclk) n_en += (core_clk_en === 1'b1);
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic set_mode(input logic [2:0] m);
    prog_mode <= 1'b1;
    bus(1, `OSC_OFS_CFG_ONE, {28'h000_0001, 1'b0, m});
    bus(0, `OSC_OFS_CFG_ONE, 32'h0000_0000);
    chk("cfg word", {28'h000_0001, 1'b0, m}, rd);
    prog_mode <= 1'b0;
  endtask
  task automatic wake;
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    n_edge = 0;
  endtask
  task automatic t_regs;
    // let the status synchronisers fill before the first read
    repeat (2) @(posedge hclk);
    bus(0, `OSC_OFS_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0028, rd);
    bus(1, `OSC_OFS_TRIM, 32'hFFFF_FFFF);
    bus(0, `OSC_OFS_TRIM, 32'h0000_0000);
    chk("trim upper", 32'h0000_003F, rd);
    bus(1, `OSC_OFS_CTRL, 32'h0000_00FF);
    bus(0, `OSC_OFS_CTRL, 32'h0000_0000);
    chk("ctrl write", 32'h0000_0038, rd);
    bus(0, 32'h0000_0040, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    chk("hresp", 32'h0000_0000, hresp);
    bus(1, `OSC_OFS_CFG_ONE, 32'h0000_0011);
    bus(0, `OSC_OFS_CFG_ONE, 32'h0000_0000);
    chk("cfg locked", 32'h0000_0000, rd);
    $display("test regs done");
  endtask
  task automatic t_xtal;
    src_run <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      set_mode(k[2:0]);
      wake;
      repeat (400) @(posedge hclk);
      wake;
      repeat (3) @(posedge hclk);
      chk("gain", 32'(k + 1), amp_gain);
      chk("held", 32'h0000_0002, {core_reset_hold, core_clk_en});
      for (i = 0; i < 8000 && core_reset_hold !== 1'b0; i++) @(posedge hclk);
      chk("count", 32'h0000_0001, n_edge >= 1024 && n_edge <= 1027);
    end
    $display("test crystal done");
  endtask
  task automatic t_ec;
    set_mode(`OSC_MODE_EC);
    gpio_oe  <= 1'b1;
    gpio_out <= 1'b1;
    wake;
    repeat (4) @(posedge hclk);
    chk("ec run", 32'h0000_0000, {amp_gain, core_reset_hold});
    chk("ec pin", 32'h0000_0003, {osc_output_pin_oe, osc_output_pin_o});
    src_run <= 1'b0;
    repeat (4) @(posedge hclk);
    n_en = 0;
    repeat (40) @(posedge hclk);
    chk("ec stopped", 32'h0000_0000, n_en);
    src_run <= 1'b1;
    repeat (40) @(posedge hclk);
    chk("ec resumed", 32'h0000_0001, n_en >= 6 && n_en <= 9);
    $display("test ec done");
  endtask
  task automatic t_rc;
    set_mode(`OSC_MODE_RC);
    wake;
    repeat (8) @(posedge hclk);
    chk("rc drive", 32'h0000_0003, {rc_osc_en, osc_output_pin_oe});
    n_tog = 0;
    n_edge = 0;
    for (i = 0; i < 200 && n_edge < 16; i++) @(posedge hclk);
    chk("rc div", 32'h0000_0001, n_tog >= 7 && n_tog <= 9);
    set_mode(`OSC_MODE_RC_NETWORK_IO_MODE);
    gpio_out <= 1'b0;
    wake;
    repeat (8) @(posedge hclk);
    chk("rc_network_io_mode pin", 32'h0000_0006, {rc_osc_en, osc_output_pin_oe, osc_output_pin_o});
    gpio_oe <= 1'b0;
    repeat (4) @(posedge hclk);
    chk("gpio in", 32'h0000_0001, gpio_in);
    bus(0, `OSC_OFS_GPIO, 32'h0000_0000);
    chk("gpio reg", 32'h0000_0001, rd);
    $display("test rc done");
  endtask
  task automatic t_por;
    for (int k = 0; k < 2; k++)
    begin
      bus(1, `OSC_OFS_TRIM, 32'h0000_002A);
      {por_event, bor_event} <= k ? 2'b01 : 2'b10;
      @(posedge hclk);
      {por_event, bor_event} <= 2'b00;
      bus(0, `OSC_OFS_TRIM, 32'h0000_0000);
      chk("trim clear", 32'h0000_0000, rd);
    end
    bus(1, `OSC_OFS_TRIM, 32'h0000_0015);
    bus(1, `OSC_OFS_CTRL, 32'h0000_0000);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `OSC_OFS_TRIM, 32'h0000_0000);
    chk("trim kept", 32'h0000_0015, rd);
    bus(0, `OSC_OFS_CTRL, 32'h0000_0000);
    chk("freq reset", 32'h0000_0028, rd);
    prog_mode <= 1'b1;
    bus(1, `OSC_OFS_CFG_ONE, 32'h0000_0004);
    prog_mode <= 1'b0;
    powerup_delay_timer_done <= 1'b0;
    por_event <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("powerup_delay_timer wait", 32'h0000_0001, core_reset_hold);
    powerup_delay_timer_done <= 1'b1;
    repeat (2) @(posedge hclk);
    por_event <= 1'b0;
    chk("powerup_delay_timer done", 32'h0000_0000, core_reset_hold);
    $display("test reset done");
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    {hsel, hwrite, por_event, bor_event, wake_event, prog_mode} = 6'h00;
    {osc_lock_in, osc_stable_in, gpio_out, gpio_oe, src_run} = 5'h10;
    {haddr, hwdata, htrans, hsize} = {64'h0000_0000_0000_0000, 5'h02};
    powerup_delay_timer_done = 1'b1;
    hresetn = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_xtal;
    t_ec;
    t_rc;
    t_por;
    finish_test;
  end
  // three full start-up counts dominate the run length
  initial
  begin
    repeat (60000) @(posedge hclk);
    num_errors++;
    $display("watchdog expired");
    finish_test;
  end
endmodule // osc_ctrl_tb_top

// File: tb/osc_src_model.sv
// stoppable external clock source for the oscillator input pin
`timescale 1ns/1ps
module osc_src_model #(
  parameter int HALF_NS = 10
) (
  input  logic run,
  output logic pin
);
  // a stopped source holds its level, as a halted external clock does
  // odd offset keeps pin edges clear of the clock edges
  initial
  begin
    pin = 1'b0;
    #1;
    forever
    begin
      #(HALF_NS);
      if (run)
        pin = ~pin;
    end
  end
endmodule // osc_src_model
